// ==== lfm_cfg.svh ====
`ifndef LFM_CFG_SVH
`define LFM_CFG_SVH

// Channel count of the transceiver
`define LFM_NCH 4
// Register port widths
`define LFM_AW 4
`define LFM_DW 32
// Register indices, one 32-bit word each
`define LFM_ADDR_CH0 4'h0
`define LFM_ADDR_CH1 4'h1
`define LFM_ADDR_CH2 4'h2
`define LFM_ADDR_CH3 4'h3
`define LFM_ADDR_GLOBAL 4'h4
`define LFM_ADDR_STATUS 4'h5
// Field widths
`define LFM_CFG_W 7
`define LFM_AMP_W 2
// Reset values, and the trip code that turns the detector off
`define LFM_CFG_RST 7'h00
`define LFM_AMP_RST 2'h0
`define LFM_AMP_OFF 2'h0
// Bit times without a transition before the stream is called dead
`define LFM_TRANS_LIMIT 7'd60
`define LFM_TRANS_W 7
// Range control interval in recovered byte clock periods
`define LFM_RANGE_PERIOD 4096
`define LFM_RANGE_W 12
`define LFM_RANGE_LAST 12'hfff

`endif

// ==== lfm_pkg.sv ====
package lfm_pkg;

    // Per-channel control word written by software
    typedef struct packed {
        logic ref_half_rate;  // Reference is bit rate / 20 when set, else / 10
        logic lco;            // local_clock_override
        logic loopback;       // local_loopback_on
        logic in_sel;         // line_input_choose: 0 picks line a, 1 picks line b
        logic rx_on;          // rx_channel_on
        logic tx_en_b;        // Driver b enable
        logic tx_en_a;        // Driver a enable
    } lfm_ch_cfg_t;

    // Per-channel inputs from the analog front end and recovery circuit
    typedef struct packed {
        logic bit_tick;       // One recovered bit is present
        logic bit_val;        // Recovered bit value
        logic byte_tick;      // Recovered byte clock edge
        logic [1:0] amp_a;    // Highest trip level exceeded on line a
        logic [1:0] amp_b;    // Highest trip level exceeded on line b
        logic ref_present;    // reference_clock_in is toggling
        logic vco_out;        // VCO deviates beyond 1500 ppm from reference
    } lfm_rx_in_t;

    // Per-channel controls toward the analog blocks
    typedef struct packed {
        logic drv_en_a;       // Driver a powered and enabled
        logic drv_en_b;       // Driver b powered and enabled
        logic tx_logic_on;    // Transmit logic power
        logic drv_static_one; // Drivers hold differential 1
        logic loop_feed;      // Transmit stream routed to recovery
        logic line_a_sel;     // serial_input_a routed to recovery
        logic line_b_sel;     // serial_input_b routed to recovery
        logic amp_det_on;     // Analog amplitude detector active
        logic pll_on;         // receive_pll and receive circuitry powered
        logic track_ref;      // Recovery forced onto the reference
        logic ref_div20;      // Reference divider is 20
    } lfm_ch_out_t;

    // Range control states
    typedef enum logic [1:0] {
        LFM_RC_WATCH = 2'b00,
        LFM_RC_FORCE = 2'b01
    } lfm_rc_state_t;

endpackage : lfm_pkg

// ==== lfm_trans_mon.sv ====
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_trans_mon (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Recovered bit stream
    input wire logic enable_i,
    input wire logic bit_tick_i,
    input wire logic bit_val_i,
    // Result
    output logic fault_o
);
    import lfm_pkg::*;

    logic [`LFM_TRANS_W-1:0] run_cnt;      // Bits since last transition
    logic [`LFM_TRANS_W-1:0] next_run_cnt;
    logic last_bit;                        // Previous bit for edge detection
    logic next_last_bit;
    logic fault;                           // Stream has gone quiet
    logic next_fault;

    // Count bits; any transition restarts the count
    always_comb begin
        next_run_cnt = run_cnt;
        next_last_bit = last_bit;
        next_fault = fault;
        if (!enable_i) begin
            // Idle channel keeps a clean count for when it comes back
            next_run_cnt = '0;
            next_fault = 1'b0;
        end else if (bit_tick_i) begin
            next_last_bit = bit_val_i;
            if (bit_val_i != last_bit) begin
                next_run_cnt = '0;
            end else if (run_cnt <= `LFM_TRANS_LIMIT) begin
                // Saturate just above the limit so the count never wraps
                next_run_cnt = run_cnt + 1'b1;
            end
            // Fault only once the count is past sixty bits
            next_fault = (bit_val_i == last_bit) && (run_cnt >= `LFM_TRANS_LIMIT);
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            run_cnt <= '0;
            last_bit <= 1'b0;
            fault <= 1'b0;
        end else begin
            run_cnt <= next_run_cnt;
            last_bit <= next_last_bit;
            fault <= next_fault;
        end
    end

    assign fault_o = fault;

endmodule : lfm_trans_mon

// ==== lfm_range_ctl.sv ====
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_range_ctl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Recovery status
    input wire logic enable_i,
    input wire logic byte_tick_i,
    input wire logic vco_out_i,
    // Result
    output logic force_o
);
    import lfm_pkg::*;

    logic [`LFM_RANGE_W-1:0] tick_cnt;     // Byte clocks in current interval
    logic [`LFM_RANGE_W-1:0] next_tick_cnt;
    lfm_rc_state_t state;
    lfm_rc_state_t next_state;

    // Sample the VCO once per interval of byte clocks
    always_comb begin
        next_tick_cnt = tick_cnt;
        next_state = state;
        if (!enable_i) begin
            next_tick_cnt = '0;
            next_state = LFM_RC_WATCH;
        end else if (byte_tick_i) begin
            next_tick_cnt = tick_cnt + 1'b1;
            if (tick_cnt == `LFM_RANGE_LAST) begin
                case (state)
                    LFM_RC_WATCH: begin
                        // Out of range: pull the VCO onto the reference
                        if (vco_out_i) begin
                            next_state = LFM_RC_FORCE;
                        end
                    end
                    LFM_RC_FORCE: begin
                        // Release to try for the data again; a still-bad
                        // VCO is caught at the next sample
                        next_state = LFM_RC_WATCH;
                    end
                    default: begin
                        next_state = LFM_RC_WATCH;
                    end
                endcase
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tick_cnt <= '0;
            state <= LFM_RC_WATCH;
        end else begin
            tick_cnt <= next_tick_cnt;
            state <= next_state;
        end
    end

    assign force_o = (state == LFM_RC_FORCE);

endmodule : lfm_range_ctl

// ==== lfm_top.sv ====
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [`LFM_AW-1:0] reg_addr_i,
    input wire logic [`LFM_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`LFM_DW-1:0] reg_rdata_o,
    // Per-channel receive status from the analog side
    input wire lfm_pkg::lfm_rx_in_t [`LFM_NCH-1:0] rx_i,
    // Per-channel analog controls
    output lfm_pkg::lfm_ch_out_t [`LFM_NCH-1:0] ch_o,
    // Link fault indicators, low means fault
    output logic [`LFM_NCH-1:0] link_fault_n_o
);
    import lfm_pkg::*;

    // Software state
    lfm_ch_cfg_t [`LFM_NCH-1:0] cfg;       // Per-channel control words
    lfm_ch_cfg_t [`LFM_NCH-1:0] next_cfg;
    logic [`LFM_AMP_W-1:0] amplitude_trip_level; // Shared by all channels
    logic [`LFM_AMP_W-1:0] next_amplitude_trip_level;
    logic [`LFM_DW-1:0] rdata;             // Read data, valid one cycle
    logic [`LFM_DW-1:0] next_rdata;

    // Monitor state
    logic [`LFM_NCH-1:0] trans_fault;      // Transition density lost
    logic [`LFM_NCH-1:0] rc_force;         // Range control forcing
    logic [`LFM_NCH-1:0] link_valid;       // All detect terms good now
    logic [`LFM_NCH-1:0] link_fault_n;     // Registered indicator
    logic [`LFM_NCH-1:0] next_link_fault_n;
    lfm_ch_out_t [`LFM_NCH-1:0] ch_out;    // Registered analog controls
    lfm_ch_out_t [`LFM_NCH-1:0] next_ch_out;

    // Amplitude check for the selected line at the shared trip level
    function automatic logic amp_ok(input logic [`LFM_AMP_W-1:0] trip,
                                    input logic [1:0] seen,
                                    input logic loopback);
        // A disabled detector never blocks the link
        if (trip == `LFM_AMP_OFF || loopback) begin
            amp_ok = 1'b1;
        end else begin
            // Front end reports the highest level it cleared
            amp_ok = (seen >= trip);
        end
    endfunction : amp_ok

    // Decode a channel register index; out-of-range gives no match
    function automatic logic ch_hit(input logic [`LFM_AW-1:0] addr, input int ch);
        case (addr)
            `LFM_ADDR_CH0: ch_hit = (ch == 0);
            `LFM_ADDR_CH1: ch_hit = (ch == 1);
            `LFM_ADDR_CH2: ch_hit = (ch == 2);
            `LFM_ADDR_CH3: ch_hit = (ch == 3);
            default: ch_hit = 1'b0;
        endcase
    endfunction : ch_hit

    // Register writes
    always_comb begin
        next_cfg = cfg;
        next_amplitude_trip_level = amplitude_trip_level;
        if (reg_wr_i) begin
            for (int i = 0; i < `LFM_NCH; i++) begin
                // Driver enables and channel enables land here
                if (ch_hit(reg_addr_i, i)) begin
                    next_cfg[i] = lfm_ch_cfg_t'(reg_wdata_i[`LFM_CFG_W-1:0]);
                end
            end
            if (reg_addr_i == `LFM_ADDR_GLOBAL) begin
                // One trip level for every receiver
                next_amplitude_trip_level = reg_wdata_i[`LFM_AMP_W-1:0];
            end
        end
    end

    // Register reads; unmapped addresses read zero
    always_comb begin
        next_rdata = '0;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LFM_ADDR_CH0: next_rdata[`LFM_CFG_W-1:0] = cfg[0];
                `LFM_ADDR_CH1: next_rdata[`LFM_CFG_W-1:0] = cfg[1];
                `LFM_ADDR_CH2: next_rdata[`LFM_CFG_W-1:0] = cfg[2];
                `LFM_ADDR_CH3: next_rdata[`LFM_CFG_W-1:0] = cfg[3];
                `LFM_ADDR_GLOBAL: begin
                    next_rdata[`LFM_AMP_W-1:0] = amplitude_trip_level;
                end
                `LFM_ADDR_STATUS: begin
                    // Fault, forcing and density status of all channels
                    next_rdata[3*`LFM_NCH-1:0] = {trans_fault, rc_force, link_fault_n};
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // Software state registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // Reset leaves every driver off and every receiver down
            for (int i = 0; i < `LFM_NCH; i++) begin
                cfg[i] <= `LFM_CFG_RST;
            end
            amplitude_trip_level <= `LFM_AMP_RST;
            rdata <= '0;
        end else begin
            cfg <= next_cfg;
            amplitude_trip_level <= next_amplitude_trip_level;
            rdata <= next_rdata;
        end
    end

    // Per-channel monitors
    for (genvar g = 0; g < `LFM_NCH; g++) begin : g_ch
        // Density watch on the recovered stream, looped or not
        lfm_trans_mon u_trans (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .enable_i(cfg[g].rx_on),
            .bit_tick_i(rx_i[g].bit_tick),
            .bit_val_i(rx_i[g].bit_val),
            .fault_o(trans_fault[g])
        );

        // Frequency watch needs both the channel and its reference
        lfm_range_ctl u_range (
            .clk_i(clk_i),
            .srst_i(srst_i),
            .enable_i(cfg[g].rx_on && rx_i[g].ref_present),
            .byte_tick_i(rx_i[g].byte_tick),
            .vco_out_i(rx_i[g].vco_out),
            .force_o(rc_force[g])
        );
    end

    // Combined signal detect and analog controls
    always_comb begin
        next_link_fault_n = link_fault_n;
        next_ch_out = ch_out;
        link_valid = '0;
        for (int i = 0; i < `LFM_NCH; i++) begin
            // Amplitude of whichever line is routed to recovery
            link_valid[i] = amp_ok(amplitude_trip_level,
                                   cfg[i].in_sel ? rx_i[i].amp_b : rx_i[i].amp_a,
                                   cfg[i].loopback)
                            && !trans_fault[i]
                            && !rx_i[i].vco_out
                            && !rc_force[i]
                            && cfg[i].rx_on
                            && rx_i[i].ref_present
                            && !cfg[i].lco;
            if (!cfg[i].rx_on) begin
                // A powered-down channel has no byte clock; hold fault
                next_link_fault_n[i] = 1'b0;
            end else if (rx_i[i].byte_tick) begin
                // Indicator moves only with the receive byte clock
                next_link_fault_n[i] = link_valid[i];
            end

            // Drivers follow their own enables
            next_ch_out[i].drv_en_a = cfg[i].tx_en_a;
            next_ch_out[i].drv_en_b = cfg[i].tx_en_b;
            // Transmit logic sleeps only with both drivers off
            next_ch_out[i].tx_logic_on = cfg[i].tx_en_a || cfg[i].tx_en_b;
            // Loopback keeps test patterns off the line
            next_ch_out[i].drv_static_one = cfg[i].loopback;
            next_ch_out[i].loop_feed = cfg[i].loopback;
            // One receiver at most, none during loopback
            next_ch_out[i].line_a_sel = !cfg[i].loopback && !cfg[i].in_sel;
            next_ch_out[i].line_b_sel = !cfg[i].loopback && cfg[i].in_sel;
            next_ch_out[i].amp_det_on = cfg[i].rx_on && !cfg[i].loopback
                                        && (amplitude_trip_level != `LFM_AMP_OFF);
            next_ch_out[i].pll_on = cfg[i].rx_on;
            // Recovery follows the reference while forced
            next_ch_out[i].track_ref = rc_force[i];
            next_ch_out[i].ref_div20 = cfg[i].ref_half_rate;
        end
    end

    // Monitor output registers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            // Link starts in fault, everything analog off
            link_fault_n <= '0;
            ch_out <= '0;
        end else begin
            link_fault_n <= next_link_fault_n;
            ch_out <= next_ch_out;
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata_o = rdata;
    assign ch_o = ch_out;
    assign link_fault_n_o = link_fault_n;

endmodule : lfm_top

// ==== lfm_remote_tx.sv ====
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_remote_tx (
    // Clock
    input wire logic clk_i,
    // Faults the bench commands per channel, and the slow mode shared by all channels
    input wire logic [`LFM_NCH-1:0] stuck_i,
    input wire logic [`LFM_NCH-1:0] vco_bad_i,
    input wire logic [`LFM_NCH-1:0] ref_ok_i,
    input wire logic [2*`LFM_NCH-1:0] amp_i,
    input wire logic slow_i,
    // Stream and status toward the receiver
    output lfm_pkg::lfm_rx_in_t [`LFM_NCH-1:0] rx_o
);
    import lfm_pkg::*;
    logic phase; // Halves the tick rate in slow mode
    logic [`LFM_NCH-1:0] bits; // Last bit sent per channel
    logic tick; // A bit and a byte clock edge are present

    initial begin
        phase = 1'b0;
        bits = '0;
    end

    assign tick = !slow_i || phase;

    // Alternating stream; a stuck channel stops toggling, which starves transitions
    // Plain always: the initial block above also writes these variables
    always @(posedge clk_i) begin
        phase <= ~phase;
        for (int c = 0; c < `LFM_NCH; c++) begin
            if (tick && !stuck_i[c]) begin
                bits[c] <= ~bits[c];
            end
        end
    end

    // Line b carries the inverse amplitude so the input choice is visible
    always_comb begin
        for (int c = 0; c < `LFM_NCH; c++) begin
            rx_o[c].bit_tick = tick;
            rx_o[c].bit_val = bits[c];
            rx_o[c].byte_tick = tick;
            rx_o[c].amp_a = amp_i[2*c +: 2];
            rx_o[c].amp_b = ~amp_i[2*c +: 2];
            rx_o[c].ref_present = ref_ok_i[c];
            rx_o[c].vco_out = vco_bad_i[c];
        end
    end
endmodule : lfm_remote_tx

// ==== lfm_top_monitor.sv ====
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_top_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [`LFM_AW-1:0] reg_addr_i,
    input wire logic [`LFM_DW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`LFM_DW-1:0] reg_rdata_o,
    // Channel side
    input wire lfm_pkg::lfm_rx_in_t [`LFM_NCH-1:0] rx_i,
    input wire lfm_pkg::lfm_ch_out_t [`LFM_NCH-1:0] ch_o,
    input wire logic [`LFM_NCH-1:0] link_fault_n_o
);
    import lfm_pkg::*;
    lfm_ch_cfg_t sh; // Channel 0 config as software wrote it
    lfm_ch_cfg_t next_sh;
    logic [1:0] trip; // Shared trip level as written
    logic [1:0] next_trip;

    // Shadow follows the write strobe, cleared by reset
    always_comb begin
        next_sh = sh;
        next_trip = trip;
        if (srst_i) begin
            next_sh = '0;
            next_trip = 2'h0;
        end else if (reg_wr_i && reg_addr_i == `LFM_ADDR_CH0) begin
            next_sh = lfm_ch_cfg_t'(reg_wdata_i[6:0]);
        end else if (reg_wr_i && reg_addr_i == `LFM_ADDR_GLOBAL) begin
            next_trip = reg_wdata_i[1:0];
        end
    end

    // Register the shadow
    always_ff @(posedge clk_i) begin
        sh <= next_sh;
        trip <= next_trip;
    end

    default clocking mon_cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    chk_drv_en_a: assert property (ch_o[0].drv_en_a == $past(sh.tx_en_a))
        else $error("driver a enable does not follow config");
    chk_tx_power: assert property (ch_o[0].tx_logic_on == (ch_o[0].drv_en_a || ch_o[0].drv_en_b))
        else $error("transmit logic power wrong");
    chk_reset_drv: assert property ($fell(srst_i) |-> ch_o[0] == '0)
        else $error("outputs not cleared by reset");
    chk_one_line: assert property (!$past(srst_i) |->
        $onehot({ch_o[0].line_a_sel, ch_o[0].line_b_sel, ch_o[0].loop_feed}))
        else $error("recovery source not exactly one");
    chk_loop_static: assert property (ch_o[0].loop_feed |-> ch_o[0].drv_static_one && !ch_o[0].amp_det_on)
        else $error("loopback outputs wrong");
    chk_amp_detect: assert property (ch_o[0].amp_det_on == $past(sh.rx_on && !sh.loopback && trip != 2'h0))
        else $error("amplitude detector enable wrong");
    chk_off_fault: assert property (!ch_o[0].pll_on |-> !link_fault_n_o[0])
        else $error("disabled channel not in fault");
    chk_vco_fault: assert property (rx_i[0].byte_tick && rx_i[0].vco_out |=> !link_fault_n_o[0])
        else $error("out of range not reported");
    chk_ref_fault: assert property (rx_i[0].byte_tick && !rx_i[0].ref_present |=> !link_fault_n_o[0])
        else $error("missing reference not reported");
    chk_force_low: assert property (ch_o[0].track_ref |-> !link_fault_n_o[0])
        else $error("link valid while forced");
    chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read cycle");
endmodule : lfm_top_monitor

bind lfm_top lfm_top_monitor lfm_top_monitor_inst (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .ch_o(ch_o),
    .link_fault_n_o(link_fault_n_o));

// ==== lfm_top_test.sv ====
`timescale 1ns/1ps
`include "lfm_cfg.svh"

module lfm_top_test;
    import lfm_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [`LFM_AW-1:0] addr = '0;
    logic [`LFM_DW-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [`LFM_DW-1:0] rdata;
    lfm_rx_in_t [`LFM_NCH-1:0] rx;
    lfm_ch_out_t [`LFM_NCH-1:0] ch;
    logic [`LFM_NCH-1:0] lfn;
    // Fault commands to the remote transmitter model
    logic [`LFM_NCH-1:0] stuck = '0;
    logic [`LFM_NCH-1:0] vco_bad = '0;
    logic [`LFM_NCH-1:0] ref_ok = '1;
    logic [2*`LFM_NCH-1:0] amp = '0;
    logic slow = 1'b0;
    int err_total = 0;
    int n_tests = 0;

    lfm_top lfm_top_inst (.clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_i(rx), .ch_o(ch),
        .link_fault_n_o(lfn));
    lfm_remote_tx lfm_remote_tx_inst (.clk_i(clk), .stuck_i(stuck), .vco_bad_i(vco_bad),
        .ref_ok_i(ref_ok), .amp_i(amp), .slow_i(slow), .rx_o(rx));

    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    // Ends the run with the verdict
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    function automatic lfm_ch_out_t exp_ch(lfm_ch_cfg_t c, logic [1:0] t);
        lfm_ch_out_t o;
        o.drv_en_a = c.tx_en_a;
        o.drv_en_b = c.tx_en_b;
        o.tx_logic_on = c.tx_en_a | c.tx_en_b;
        o.drv_static_one = c.loopback;
        o.loop_feed = c.loopback;
        o.line_a_sel = !c.loopback && !c.in_sel;
        o.line_b_sel = !c.loopback && c.in_sel;
        o.amp_det_on = c.rx_on && !c.loopback && t != 2'h0;
        o.pll_on = c.rx_on;
        o.track_ref = 1'b0;
        o.ref_div20 = c.ref_half_rate;
        return o;
    endfunction : exp_ch

    // Loopback and trip code 0 bypass the amplitude check
    function automatic logic exp_lfn(lfm_ch_cfg_t c, logic [1:0] t, logic [1:0] a, logic r);
        logic [1:0] s;
        s = c.in_sel ? ~a : a;
        return (t == 2'h0 || c.loopback || s >= t) && c.rx_on && r && !c.lco;
    endfunction : exp_lfn

    task automatic do_reset();
        @(posedge clk);
        srst <= 1'b1;
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        for (int c = 0; c < `LFM_NCH; c++) begin
            cmp(32'(ch[c]), 32'(exp_ch('0, 2'h0)));
        end
        cmp(32'(lfn), 32'h0);
    endtask : do_reset

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        lfm_ch_cfg_t cfg [`LFM_NCH];
        logic [1:0] trip;
        logic [31:0] d;
        logic [31:0] st;
        int n;
        void'($urandom(32'h87ed));
        do_reset();
        $display("test reset done");
        // Random configurations across every trip code and both lines
        for (int i = 0; i < 24; i++) begin
            trip = 2'(i % 4);
            @(posedge clk);
            amp <= 8'($urandom);
            // Channel 0 may lose its reference so the missing-reference path is hit
            ref_ok <= 4'($urandom) | 4'h8;
            slow <= 1'($urandom);
            for (int c = 0; c < `LFM_NCH; c++) begin
                cfg[c] = lfm_ch_cfg_t'(7'($urandom));
                wr_reg(4'(c), 32'(cfg[c]));
            end
            wr_reg(`LFM_ADDR_GLOBAL, 32'(trip));
            wr_reg(4'hf, 32'($urandom));
            repeat (6) @(posedge clk);
            #1 st = '0;
            for (int c = 0; c < `LFM_NCH; c++) begin
                cmp(32'(ch[c]), 32'(exp_ch(cfg[c], trip)));
                st[c] = exp_lfn(cfg[c], trip, amp[2*c +: 2], ref_ok[c]);
            end
            cmp(32'(lfn), st);
            rd_reg(`LFM_ADDR_STATUS, d);
            cmp(d, st);
            rd_reg(4'(i % 4), d);
            cmp(d, 32'(cfg[i % 4]));
            rd_reg(`LFM_ADDR_GLOBAL, d);
            cmp(d, 32'(trip));
            rd_reg(4'hf, d);
            cmp(d, 32'h0);
        end
        $display("test random config done");
        // Transition starvation on channel 0, restart of the count
        @(posedge clk);
        slow <= 1'b0;
        ref_ok <= '1;
        wr_reg(`LFM_ADDR_CH0, 32'h04);
        wr_reg(`LFM_ADDR_GLOBAL, 32'h0);
        stuck <= 4'h1;
        repeat (55) @(posedge clk);
        stuck <= 4'h0;
        #1 cmp(32'(lfn[0]), 32'h1);
        @(posedge clk);
        stuck <= 4'h1;
        repeat (55) @(posedge clk);
        #1 cmp(32'(lfn[0]), 32'h1);
        repeat (15) @(posedge clk);
        #1 cmp(32'(lfn[0]), 32'h0);
        // Density fault shows in status while the stream stays stuck
        rd_reg(`LFM_ADDR_STATUS, d);
        cmp(32'({d[8], d[0]}), 32'h2);
        @(posedge clk);
        stuck <= 4'h0;
        repeat (5) @(posedge clk);
        #1 cmp(32'(lfn[0]), 32'h1);
        $display("test transitions done");
        // Range control forces and releases after one interval
        @(posedge clk);
        vco_bad <= 4'h1;
        repeat (3) @(posedge clk);
        #1 cmp(32'(lfn[0]), 32'h0);
        n = 0;
        while (ch[0].track_ref !== 1'b1 && n < 4200) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(32'(ch[0].track_ref), 32'h1);
        // Forcing shows in status, with the link in fault
        rd_reg(`LFM_ADDR_STATUS, d);
        cmp(32'({d[4], d[0]}), 32'h2);
        @(posedge clk);
        vco_bad <= 4'h0;
        // Three high cycles of the forced span have passed by now
        n = 3;
        while (ch[0].track_ref === 1'b1 && n < 5000) begin
            @(posedge clk);
            #1 n++;
        end
        cmp(32'(n), 32'd4096);
        repeat (4) @(posedge clk);
        #1 cmp(32'(lfn[0]), 32'h1);
        $display("test range control done");
        // Reset in mid-run with drivers enabled
        wr_reg(`LFM_ADDR_CH1, 32'h07);
        do_reset();
        rd_reg(`LFM_ADDR_CH1, d);
        cmp(d, 32'h0);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule : lfm_top_test
